// ===== shared/fsm_pkg.sv
package fsm_pkg;

   // register map, byte addresses on the serial control interface
   localparam logic [7:0] FSM_ADDR_STICKY    = 8'h6D;
   localparam logic [7:0] FSM_ADDR_CFG       = 8'h75;
   localparam logic [7:0] FSM_ADDR_LIVE      = 8'h7C;
   localparam logic [7:0] FSM_ADDR_CLEAR     = 8'h2D;

   // reset values
   localparam logic [7:0] FSM_RST_FLAGS      = 8'h00;
   localparam logic [7:0] FSM_RST_CFG        = 8'h00;
   localparam logic [7:0] FSM_RST_RDATA      = 8'h00;

   // field layout
   localparam int         FSM_FAULT_W        = 8;
   localparam int         FSM_CFG_W          = 3;
   localparam int         FSM_CLEAR_BIT      = 1;

   // fault bit positions, same in both fault registers
   localparam int         FSM_BIT_FLYCAP_OV  = 0;
   localparam int         FSM_BIT_OVERCUR    = 1;
   localparam int         FSM_BIT_CLK_LOCK   = 2;
   localparam int         FSM_BIT_SUPPLY_UV  = 3;
   localparam int         FSM_BIT_OT_WARN    = 4;
   localparam int         FSM_BIT_OT_ERR     = 5;
   localparam int         FSM_BIT_PIN_SHORT  = 6;
   localparam int         FSM_BIT_DC_PROT    = 7;

   // output stage configuration codes
   typedef enum logic [2:0] {
      FSM_CFG_BRIDGED_LOAD      = 3'h0,
      FSM_CFG_SINGLE_ENDED_LOAD = 3'h1,
      FSM_CFG_MIXED_LOAD        = 3'h2,
      FSM_CFG_PARALLEL_BRIDGED  = 3'h3
   } fsm_cfg_type;

   // clear toggle detector states
   typedef enum logic [1:0] {
      FSM_CLR_IDLE = 2'b00,
      FSM_CLR_HIGH = 2'b01
   } fsm_clr_state_type;

   // register access request from the serial interface
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fsm_req_type;

endpackage : fsm_pkg

// ===== hdl/fsm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fsm_sync
   import fsm_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock, reset and enable
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // asynchronous level in, filtered level out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // three stages; a change is taken once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_q[gi]   <= 1'b0;
               s2_q[gi]     <= 1'b0;
               s3_q[gi]     <= 1'b0;
               sync_out[gi] <= 1'b0;
            end else if (ce) begin
               meta_q[gi] <= async_in[gi];
               s2_q[gi]   <= meta_q[gi];
               s3_q[gi]   <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) begin
                  sync_out[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate

endmodule : fsm_sync
`default_nettype wire

// ===== hdl/fsm_regs.sv
`timescale 1ns/1ps
`default_nettype none
module fsm_regs
   import fsm_pkg::*;
(
   // clock, reset, enable
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   // fault sources, asynchronous levels, high when triggered
   input  wire logic                   flycap_ov,
   input  wire logic                   overcur,
   input  wire logic                   clk_lock_err,
   input  wire logic                   supply_uv,
   input  wire logic                   ot_warn,
   input  wire logic                   ot_err,
   input  wire logic                   pin_short,
   input  wire logic                   dc_prot,
   // configuration select pins, asynchronous
   input  wire logic [FSM_CFG_W-1:0]   cfg_sel,
   // register access from the serial interface, same clock
   input  wire fsm_req_type            req,
   output logic      [7:0]             rdata,
   output logic                        rvalid,
   // register contents
   output logic      [FSM_FAULT_W-1:0] live_q,
   output logic      [FSM_FAULT_W-1:0] sticky_q,
   output logic      [FSM_CFG_W-1:0]   cfg_q
);

   logic [FSM_FAULT_W-1:0] raw_faults;
   logic [FSM_FAULT_W-1:0] live_s;
   logic [FSM_CFG_W-1:0]   cfg_s;
   logic                   clr_bit_q;
   logic                   clr_bit_prev_q;
   logic                   clear_pulse_d;
   fsm_clr_state_type      clr_state_q;
   logic [7:0]             rdata_d;

   assign raw_faults[FSM_BIT_FLYCAP_OV] = flycap_ov;
   assign raw_faults[FSM_BIT_OVERCUR]   = overcur;
   assign raw_faults[FSM_BIT_CLK_LOCK]  = clk_lock_err;
   assign raw_faults[FSM_BIT_SUPPLY_UV] = supply_uv;
   assign raw_faults[FSM_BIT_OT_WARN]   = ot_warn;
   assign raw_faults[FSM_BIT_OT_ERR]    = ot_err;
   assign raw_faults[FSM_BIT_PIN_SHORT] = pin_short;
   assign raw_faults[FSM_BIT_DC_PROT]   = dc_prot;

   fsm_sync #(
      .WIDTH (FSM_FAULT_W)
   ) u_sync_fault (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .async_in (raw_faults),
      .sync_out (live_s)
   );

   fsm_sync #(
      .WIDTH (FSM_CFG_W)
   ) u_sync_cfg (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .async_in (cfg_sel),
      .sync_out (cfg_s)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         live_q <= FSM_RST_FLAGS;
      end else if (ce) begin
         live_q <= live_s;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q <= FSM_RST_CFG[FSM_CFG_W-1:0];
      end else if (ce) begin
         cfg_q <= cfg_s;
      end
   end

   // fault latch clear control bit, host writable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clr_bit_q <= 1'b0;
      end else if (ce && req.wr && req.addr == FSM_ADDR_CLEAR) begin
         clr_bit_q <= req.wdata[FSM_CLEAR_BIT];
      end
   end

   // clear bit as seen at the last enabled edge, so a frozen gap does not hide the high phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clr_bit_prev_q <= 1'b0;
      end else if (ce) begin
         clr_bit_prev_q <= clr_bit_q;
      end
   end

   always_comb begin
      clear_pulse_d = 1'b0;
      case (clr_state_q)
         FSM_CLR_IDLE: clear_pulse_d = 1'b0;
         FSM_CLR_HIGH: clear_pulse_d = !clr_bit_q;
         default:      clear_pulse_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clr_state_q <= FSM_CLR_IDLE;
      end else if (ce) begin
         case (clr_state_q)
            FSM_CLR_IDLE: begin
               if (clr_bit_q) begin
                  clr_state_q <= FSM_CLR_HIGH;
               end
            end
            FSM_CLR_HIGH: begin
               if (!clr_bit_q) begin
                  clr_state_q <= FSM_CLR_IDLE;
               end
            end
            default: clr_state_q <= FSM_CLR_IDLE;
         endcase
      end
   end

   // accumulate; clear, set wins over clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sticky_q <= FSM_RST_FLAGS;
      end else if (ce) begin
         if (clear_pulse_d) begin
            sticky_q <= live_s;
         end else begin
            sticky_q <= sticky_q | live_s;
         end
      end
   end

   // read mux; writes to monitor addresses have no decode
   always_comb begin
      rdata_d = FSM_RST_RDATA;
      case (req.addr)
         FSM_ADDR_STICKY: rdata_d = sticky_q;
         FSM_ADDR_LIVE:   rdata_d = live_q;
         FSM_ADDR_CFG:    rdata_d = {{(8-FSM_CFG_W){1'b0}}, cfg_q};
         FSM_ADDR_CLEAR: begin
            rdata_d[FSM_CLEAR_BIT] = clr_bit_q;
         end
         default:         rdata_d = FSM_RST_RDATA;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata  <= FSM_RST_RDATA;
         rvalid <= 1'b0;
      end else if (ce) begin
         rvalid <= req.rd;
         if (req.rd) begin
            rdata <= rdata_d;
         end
      end
   end

   // a live fault is in the sticky register next cycle
   chk_sticky_holds_live: assert property (@(posedge clk) disable iff (rst)
      ce && !clear_pulse_d |=> ((sticky_q & $past(live_s)) == $past(live_s)))
      else $error("sticky register missed a live fault");

   // clear leaves only faults present now
   chk_clear_zeroes: assert property (@(posedge clk) disable iff (rst)
      ce && clear_pulse_d |=> (sticky_q == $past(live_s)))
      else $error("sticky clear did not reset bits");

   // toggle required: clear only after high then low
   chk_toggle_order: assert property (@(posedge clk) disable iff (rst)
      ce && clear_pulse_d |-> (clr_bit_prev_q && !clr_bit_q))
      else $error("clear fired without low-high-low toggle");

   // sticky bits never drop without clear
   chk_sticky_keep: assert property (@(posedge clk) disable iff (rst)
      ce && !clear_pulse_d |=> ((sticky_q & $past(sticky_q)) == $past(sticky_q)))
      else $error("sticky bit dropped without clear");

   // live register follows the filtered sources
   chk_live_follow: assert property (@(posedge clk) disable iff (rst)
      ce |=> (live_q == $past(live_s)))
      else $error("live register does not follow sources");

   chk_cfg_follow: assert property (@(posedge clk) disable iff (rst)
      ce |=> (cfg_q == $past(cfg_s)))
      else $error("configuration readback stale");

   chk_write_ignored: assert property (@(posedge clk) disable iff (rst)
      ce && req.wr && req.addr == FSM_ADDR_LIVE && live_s == live_q |=> $stable(live_q))
      else $error("write disturbed live register");

   // read of sticky returns its content
   chk_read_sticky: assert property (@(posedge clk) disable iff (rst)
      ce && req.rd && req.addr == FSM_ADDR_STICKY |=> rvalid && rdata == $past(sticky_q))
      else $error("sticky read returned wrong data");

endmodule : fsm_regs
`default_nettype wire

// ===== testbench/fsm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsm_host_model
   import fsm_pkg::*;
(
   // clock
   input  wire logic       clk,
   // register access
   output var fsm_req_type req,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid
);
   initial req = '0;
   // released lines show the inverse of their last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(negedge clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'hXX;
      @(negedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      for (int n = 0; n < 4; n++) begin
         @(negedge clk);
         req <= '{1'b0, 1'b0, ~a, 8'hFF};
         if (rvalid === 1'b1) begin
            d = rdata;
            break;
         end
      end
   endtask : rd
endmodule : fsm_host_model
`default_nettype wire

// ===== testbench/fsm_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fsm_regs_bench
   import fsm_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce  = 1'b1;
   logic [7:0]  flt = 8'h00;
   logic [2:0]  sel = 3'h0;
   fsm_req_type req;
   logic [7:0]  rdata, live_q, sticky_q, acc, p;
   logic [2:0]  cfg_q;
   logic        rvalid;
   int          seed = 29055;
   int          fails = 0;
   int          checks = 0;
   logic [7:0]  ad [3] = '{FSM_ADDR_STICKY, FSM_ADDR_CFG, FSM_ADDR_LIVE};

   always #25 clk = ~clk;

   fsm_regs i_fsm_regs (
      .clk(clk), .rst(rst), .ce(ce),
      .flycap_ov(flt[0]), .overcur(flt[1]), .clk_lock_err(flt[2]), .supply_uv(flt[3]),
      .ot_warn(flt[4]), .ot_err(flt[5]), .pin_short(flt[6]), .dc_prot(flt[7]),
      .cfg_sel(sel), .req(req), .rdata(rdata), .rvalid(rvalid),
      .live_q(live_q), .sticky_q(sticky_q), .cfg_q(cfg_q)
   );
   fsm_host_model i_fsm_host_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

   function automatic logic [7:0] exp_cfg(input logic [2:0] c);
      return {5'h00, c};
   endfunction : exp_cfg

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      i_fsm_host_model.rd(a, v);
      chk($sformatf("read %h", a), e, v);
   endtask : rdchk
   task automatic settle();
      repeat (8) @(negedge clk);
   endtask : settle
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #(50 * 4000);
      fails++;
      tally_and_finish();
   end

   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("live_q", FSM_RST_FLAGS, live_q);
      chk("cfg_q", FSM_RST_CFG, {5'h00, cfg_q});
      for (int i = 0; i < 3; i++) rdchk(ad[i], 8'h00);
      $display("test reset done");
      acc = 8'h00;
      for (int k = 0; k < 16; k++) begin
         if (k == 8) begin
            // only low then high: no clear yet
            i_fsm_host_model.wr(FSM_ADDR_CLEAR, 8'h00);
            i_fsm_host_model.wr(FSM_ADDR_CLEAR, 8'(1 << FSM_CLEAR_BIT));
            settle();
            chk("sticky_q", acc, sticky_q);
            rdchk(FSM_ADDR_CLEAR, 8'(1 << FSM_CLEAR_BIT));
            i_fsm_host_model.wr(FSM_ADDR_CLEAR, 8'h00);
            settle();
            acc = 8'h00;
            rdchk(FSM_ADDR_STICKY, acc);
         end
         p = (k < 8) ? 8'(1 << k) : 8'($random(seed));
         flt = p;
         settle();
         acc = acc | p;
         rdchk(FSM_ADDR_LIVE, p);
         chk("live_q", p, live_q);
         rdchk(FSM_ADDR_STICKY, acc);
         flt = 8'h00;
         settle();
         chk("live_q", 8'h00, live_q);
         chk("sticky_q", acc, sticky_q);
      end
      $display("test faults done");
      // a fault present during the clear survives it
      p = 8'h81;
      flt = p;
      settle();
      i_fsm_host_model.wr(FSM_ADDR_CLEAR, 8'(1 << FSM_CLEAR_BIT));
      i_fsm_host_model.wr(FSM_ADDR_CLEAR, 8'h00);
      settle();
      chk("sticky_q", p, sticky_q);
      flt = 8'h00;
      settle();
      acc = p;
      rdchk(FSM_ADDR_STICKY, acc);
      $display("test clear corner done");
      for (int i = 0; i < 3; i++) i_fsm_host_model.wr(ad[i], 8'($random(seed)));
      rdchk(FSM_ADDR_STICKY, acc);
      rdchk(FSM_ADDR_CFG, exp_cfg(sel));
      rdchk(FSM_ADDR_LIVE, 8'h00);
      $display("test writes done");
      for (int c = 3; c >= 0; c--) begin
         sel = 3'(c);
         settle();
         rdchk(FSM_ADDR_CFG, exp_cfg(sel));
         chk("cfg_q", exp_cfg(sel), {5'h00, cfg_q});
      end
      rdchk(8'h10, FSM_RST_RDATA);
      $display("test config done");
      // enable low freezes the fault registers and drops the host write
      ce = 1'b0;
      flt = 8'h3C;
      i_fsm_host_model.wr(FSM_ADDR_CLEAR, 8'(1 << FSM_CLEAR_BIT));
      settle();
      chk("live_q", 8'h00, live_q);
      chk("sticky_q", acc, sticky_q);
      ce = 1'b1;
      settle();
      chk("live_q", 8'h3C, live_q);
      chk("sticky_q", acc | 8'h3C, sticky_q);
      rdchk(FSM_ADDR_CLEAR, 8'h00);
      flt = 8'h00;
      settle();
      $display("test enable done");
      // reset in mid-run empties both fault registers
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("sticky_q", FSM_RST_FLAGS, sticky_q);
      chk("live_q", FSM_RST_FLAGS, live_q);
      rdchk(FSM_ADDR_STICKY, FSM_RST_FLAGS);
      rdchk(FSM_ADDR_CLEAR, 8'h00);
      $display("test reset again done");
      tally_and_finish();
   end
endmodule : fsm_regs_bench
`default_nettype wire
